// ===== design/sar_seq_pkg.sv
// shared constants and types for the conversion sequencer
package sar_seq_pkg;

    // ==========================================
    // widths and reset values
    localparam int          RESULT_WIDTH = 12;
    localparam int          PTR_WIDTH    = 4;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [3:0]  PTR_MSB      = 4'hB;
    localparam logic [3:0]  PTR_LSB      = 4'h0;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int ACQ_TIME_NS   = 1000;
    localparam int ACQ_CYCLES    = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================
    // sequencer phases
    typedef enum logic [1:0] {
        ph_sample,
        ph_wait_edge,
        ph_convert,
        ph_latch
    } phase_t;

endpackage

// ===== design/conv_events_if.sv
// event carrier between the edge and start detectors and the sequencer
`timescale 1ns/10ps
interface conv_events_if;
    logic start_req;
    logic clk_rise;
    logic clk_fall;

    modport start_src (output start_req);
    modport edge_src  (output clk_rise, output clk_fall);
    modport sink      (input start_req, input clk_rise, input clk_fall);
endinterface

// ===== design/conv_clk_edges.sv
// edge detection of the converter clock input
`timescale 1ns/10ps
module conv_clk_edges (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       conv_clk_in,
    conv_events_if.edge_src ev
);
    import sar_seq_pkg::*;

    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t st;
    edge_state_t next_st;

    // ==========================================
    // state update
    always_comb begin
        next_st      = st;
        next_st.prev = conv_clk_in;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // either polarity and any duty cycle: only transitions are used
    assign ev.clk_rise = conv_clk_in & ~st.prev;
    assign ev.clk_fall = ~conv_clk_in & st.prev;

endmodule // conv_clk_edges

// ===== design/conv_start_detect.sv
// start condition detection from the host strobes
`timescale 1ns/10ps
module conv_start_detect (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        high_byte_select,
    conv_events_if.start_src ev
);
    import sar_seq_pkg::*;

    typedef struct packed {
        logic read_prev_n;
    } start_state_t;

    start_state_t st;
    start_state_t next_st;

    // ==========================================
    // state update
    always_comb begin
        next_st             = st;
        next_st.read_prev_n = read_n;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    // start only on read falling with select and high byte select low
    assign ev.start_req = st.read_prev_n & ~read_n & ~select_n & ~high_byte_select;

endmodule // conv_start_detect

// ===== design/sar_conversion_sequencer.sv
// successive approximation conversion sequencer, top level
// Operation
// - start decided only from select, read and high byte select together
// - at start, clear approximation register; data drivers on whenever select and read are low
// - start conditions ignored while a conversion runs
// - bit trials run from msb down to lsb over 12 bits
// - sampling phase holds from conversion end until next start
// - msb decided at second converter clock falling edge after start
// - each further bit decided on the next converter clock falling edge
// - finished approximation register copied into 12-bit result latch
// - clock output is always the inverse of clock input
// - start near either clock edge still yields a valid conversion
// - result is unsigned natural binary, lsb is full scale over 4096
// - works from crystal or external clock of any duty cycle
// - busy low throughout a conversion, high otherwise
// - start when read falls with select and high byte select low
// - high byte select high blocks starts
`timescale 1ns/10ps
module sar_conversion_sequencer #(
    parameter int RESULT_WIDTH = sar_seq_pkg::RESULT_WIDTH
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    conv_clk_in,
    input  wire logic                    select_n,
    input  wire logic                    read_n,
    input  wire logic                    high_byte_select,
    input  wire logic                    comp_above,
    output logic                         clk_out,
    output logic                         busy_n,
    output logic                         sample_phase,
    output logic [RESULT_WIDTH-1:0]      trial_code,
    output logic [RESULT_WIDTH-1:0]      data_out,
    output logic                         data_oe
);
    import sar_seq_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        phase_t                  phase;
        logic [RESULT_WIDTH-1:0] approximation_register;
        logic [RESULT_WIDTH-1:0] trial;
        logic [PTR_WIDTH-1:0]    ptr;
        logic [RESULT_WIDTH-1:0] result;
        logic                    busy_n;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    conv_events_if ev ();

    // ==========================================
    // event sources
    conv_clk_edges u_edges (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .conv_clk_in (conv_clk_in),
        .ev          (ev.edge_src)
    );

    conv_start_detect u_start (
        .clk_sys          (clk_sys),
        .reset_n          (reset_n),
        .select_n         (select_n),
        .read_n           (read_n),
        .high_byte_select (high_byte_select),
        .ev               (ev.start_src)
    );

    // ==========================================
    // sequencer
    always_comb begin
        next_st = st;
        unique case (st.phase)
            ph_sample: begin
                if (ev.start_req) begin
                    next_st.phase                  = ph_wait_edge;
                    next_st.approximation_register = '0;
                    next_st.ptr                    = PTR_MSB;
                    next_st.trial                  = RESULT_WIDTH'(1) << PTR_MSB;
                    next_st.busy_n                 = 1'b0;
                end
            end
            ph_wait_edge: begin
                // first falling edge passes, msb decided on the second
                if (ev.clk_fall) begin
                    next_st.phase = ph_convert;
                end
            end
            ph_convert: begin
                if (ev.clk_fall) begin
                    next_st.approximation_register[st.ptr] = comp_above;
                    if (st.ptr == PTR_LSB) begin
                        next_st.phase = ph_latch;
                        next_st.trial = '0;
                    end else begin
                        next_st.ptr   = st.ptr - PTR_WIDTH'(1);
                        next_st.trial = (st.trial & ~(RESULT_WIDTH'(1) << st.ptr))
                                      | (RESULT_WIDTH'(comp_above) << st.ptr)
                                      | (RESULT_WIDTH'(1) << (st.ptr - PTR_WIDTH'(1)));
                    end
                end
            end
            ph_latch: begin
                next_st.result = st.approximation_register;
                next_st.busy_n = 1'b1;
                next_st.phase  = ph_sample;
            end
        endcase
        // starts outside the sampling phase fall through unused
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.phase                  <= ph_sample;
            st.approximation_register <= RESULT_RESET;
            st.trial                  <= RESULT_RESET;
            st.ptr                    <= PTR_MSB;
            st.result                 <= RESULT_RESET;
            st.busy_n                 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // outputs
    assign clk_out      = ~conv_clk_in;
    assign busy_n       = st.busy_n;
    assign sample_phase = (st.phase == ph_sample);
    assign trial_code   = st.trial;
    assign data_out     = st.result;
    assign data_oe      = ~select_n & ~read_n;

endmodule // sar_conversion_sequencer

// ===== dv/analog_model.sv
// comparator model of the analog far side
`timescale 1ns/10ps
module analog_model (
    input  wire logic [11:0] trial_code,
    input  wire logic [11:0] level,
    output logic             comp_above
);
    // keep the trial bit while the held input reaches the trial word
    assign comp_above = (level >= trial_code);
endmodule // analog_model

// ===== dv/sar_seq_properties.sv
// port assertions for the conversion sequencer
`timescale 1ns/10ps
module sar_seq_checker #(
    parameter int RESULT_WIDTH = 12
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic conv_clk_in,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic high_byte_select,
    input wire logic clk_out,
    input wire logic busy_n,
    input wire logic sample_phase,
    input wire logic [RESULT_WIDTH-1:0] trial_code,
    input wire logic [RESULT_WIDTH-1:0] data_out
);
    logic       clk_q;
    logic [3:0] falls;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========
    // converter clock falls counted while busy
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clk_q <= 1'b0;
            falls <= 4'h0;
        end else begin
            clk_q <= conv_clk_in;
            falls <= busy_n ? 4'h0 : falls + 4'(clk_q && !conv_clk_in);
        end
    end
    a_clk_inverse: assert property (clk_out == !conv_clk_in)
        else $error("clock out not inverted");
    a_start_taken: assert property ($fell(read_n) && !select_n && !high_byte_select
        && busy_n && sample_phase |=> !busy_n) else $error("start missed");
    a_start_blocked: assert property ($fell(read_n) && (high_byte_select || select_n)
        && busy_n |=> busy_n) else $error("blocked start taken");
    a_busy_convert: assert property (!busy_n |-> !sample_phase)
        else $error("busy in sample phase");
    a_sample_holds: assert property (busy_n && $past(busy_n) |-> sample_phase)
        else $error("left sample phase");
    a_start_clear: assert property ($fell(busy_n) |-> (trial_code == 12'h800)[*4])
        else $error("bad first trial");
    a_no_restart: assert property ($fell(busy_n) |-> !busy_n[*8])
        else $error("conversion cut short");
    a_result_hold: assert property (!busy_n && !$past(busy_n) |-> $stable(data_out))
        else $error("result moved while busy");
    a_bit_edges: assert property ($rose(busy_n) |-> falls == 4'hD)
        else $error("wrong decision count");
    c_done: cover property ($rose(busy_n));
    c_blocked: cover property ($fell(read_n) && high_byte_select);
    c_retry: cover property ($fell(read_n) && !busy_n);
endmodule // sar_seq_checker
bind sar_conversion_sequencer sar_seq_checker #(.RESULT_WIDTH(RESULT_WIDTH)) i_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .conv_clk_in(conv_clk_in), .select_n(select_n),
    .read_n(read_n), .high_byte_select(high_byte_select), .clk_out(clk_out),
    .busy_n(busy_n), .sample_phase(sample_phase), .trial_code(trial_code),
    .data_out(data_out));

// ===== dv/testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module testbench;
    import sar_seq_pkg::*;
    logic        clk_sys, reset_n, conv_clk_in, select_n, read_n, high_byte_select;
    logic        comp_above, clk_out, busy_n, sample_phase, data_oe;
    logic [11:0] trial_code, data_out, level;
    logic [11:0] exp_q[$];
    logic [11:0] vals[4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
    int          bad_count, samples_checked;
    sar_conversion_sequencer i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .conv_clk_in(conv_clk_in), .select_n(select_n), .read_n(read_n),
        .high_byte_select(high_byte_select), .comp_above(comp_above), .clk_out(clk_out),
        .busy_n(busy_n), .sample_phase(sample_phase), .trial_code(trial_code),
        .data_out(data_out), .data_oe(data_oe));
    analog_model i_far (.trial_code(trial_code), .level(level), .comp_above(comp_above));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // converter clock, uneven duty, off the system edges
    initial begin
        conv_clk_in = 1'b0;
        #7;
        forever begin
            conv_clk_in = 1'b1;
            #30;
            conv_clk_in = 1'b0;
            #70;
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one host read strobe, then wait out the conversion and the acquisition gap
    task automatic conv(input logic [11:0] v, input logic s, input logic h);
        repeat ($urandom_range(0, 3)) @(posedge clk_sys);
        level <= v;
        select_n <= s;
        high_byte_select <= h;
        read_n <= 1'b0;
        if (!s && !h) exp_q.push_back(v);
        @(negedge clk_sys);
        check({11'h000, data_oe}, {11'h000, ~s});
        repeat (3) @(posedge clk_sys);
        read_n <= 1'b1;
        select_n <= 1'b1;
        high_byte_select <= 1'b0;
        @(negedge clk_sys);
        check({10'h000, busy_n, data_oe}, {10'h000, s | h, 1'b0});
        for (int i = 0; i < 200 && busy_n !== 1'b1; i++) @(negedge clk_sys);
        check({11'h000, busy_n}, 12'h001);
        repeat (ACQ_CYCLES) @(posedge clk_sys);
        $display("test with %h done", v);
    endtask
    // result watcher
    initial forever begin
        @(posedge busy_n);
        @(negedge clk_sys);
        if (reset_n) begin
            if (exp_q.size() > 0) begin
                check(data_out, exp_q.pop_front());
            end else begin
                bad_count++;
                $display("[ERR] %0t result without a start", $time);
            end
        end
    end
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #500us;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        select_n = 1'b1;
        read_n = 1'b1;
        high_byte_select = 1'b0;
        level = 12'h000;
        void'($urandom(44084));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (vals[i]) conv(vals[i], 1'b0, 1'b0);
        repeat (4) conv(12'($urandom), 1'b0, 1'b0);
        conv(12'h321, 1'b0, 1'b1);
        conv(12'h321, 1'b1, 1'b0);
        fork
            conv(12'h5A3, 1'b0, 1'b0);
            begin
                repeat (20) @(posedge clk_sys);
                select_n <= 1'b0;
                read_n <= 1'b0;
                repeat (2) @(posedge clk_sys);
                select_n <= 1'b1;
                read_n <= 1'b1;
            end
        join
        fork
            conv(12'hA5C, 1'b0, 1'b0);
            begin
                repeat (30) @(posedge clk_sys);
                reset_n <= 1'b0;
                repeat (2) @(posedge clk_sys);
                reset_n <= 1'b1;
                exp_q.delete();
                @(negedge clk_sys);
                check(data_out, 12'h000);
            end
        join
        conv(12'h9B4, 1'b0, 1'b0);
        end_sim();
    end
endmodule // testbench
